/* File: design/coex_handshake.sv */
// Purpose : Device end of the antenna-sharing handshake with a WLAN radio
// Assumes : All inputs synchronous to CLK_SYS; the WLAN side drives PERMIT_N
// Notes   : Three arrangements chosen on MODE_SEL, sampled while idle
module coex_handshake
   import coex_pkg::*;
#(
   parameter int PRIO_CYC = PRIO_PHASE_CYC
)
(
   input  wire logic        CLK_SYS,
   input  wire logic        RST,
   input  wire logic [1:0]  MODE_SEL,
   input  wire logic        ACT_PEND,
   input  wire logic        ACT_HIGH_PRIO,
   input  wire logic        ACT_KIND,
   input  wire logic        ACT_DONE,
   input  wire logic        PERMIT_N,
   output logic             REQ_OUT,
   output logic             PRIO_OUT,
   output logic             RADIO_GO,
   output logic             RADIO_ABORT,
   output logic             REFUSED
);

   hs_state_t         state_q;
   logic [1:0]        mode_q;
   logic              kind_q;
   logic              prio_q;
   logic [CNT_W-1:0]  cnt_q;
   logic              cnt_done;
   logic              sel_one_req;
   logic              sel_one_permit;
   logic              run_three;
   logic              run_one_permit;

   coex_sync_if sif ();

   assign sif.permit_raw = PERMIT_N;

   // ------------------------------------------------------------------
   // Arrangement decode
   // ------------------------------------------------------------------
   // Live selection steers the idle decision; the latched copy steers the
   // rest so a change on MODE_SEL mid-activity has no effect. Code 3 is
   // not a defined arrangement and falls back to three-wire.
   assign sel_one_req    = (MODE_SEL == MODE_ONE_REQUEST);
   assign sel_one_permit = (MODE_SEL == MODE_ONE_PERMIT);
   assign run_three      = (mode_q != MODE_ONE_REQUEST) && (mode_q != MODE_ONE_PERMIT);
   assign run_one_permit = (mode_q == MODE_ONE_PERMIT);

   // ------------------------------------------------------------------
   // Permit conditioning
   // ------------------------------------------------------------------
   coex_permit_filter u_filt (
      .clk (CLK_SYS),
      .rst (RST),
      .sif (sif)
   );

   assign cnt_done = (cnt_q == CNT_W'(PRIO_CYC - 1));

   // ------------------------------------------------------------------
   // Activity capture
   // ------------------------------------------------------------------
   // Mode is latched only in idle so a live activity never changes rules;
   // MODE_SEL may move freely while an activity runs
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         mode_q <= MODE_THREE_WIRE;
      end else if (state_q == ST_IDLE) begin
         mode_q <= MODE_SEL;
      end
   end

   // Kind and priority are taken with the request; request-only always claims top priority
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         kind_q <= KIND_RX;
         prio_q <= 1'b0;
      end else if (state_q == ST_IDLE && ACT_PEND) begin
         kind_q <= ACT_KIND;
         prio_q <= sel_one_req ? 1'b1 : ACT_HIGH_PRIO;
      end
   end

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   // Idle picks the path from the live selection, later states follow the
   // latched one so the arrangement cannot change under a running activity
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (ACT_PEND) begin
                  if (sel_one_req) begin
                     state_q <= ST_ACTIVE;
                  end else if (sel_one_permit) begin
                     state_q <= ST_WAIT;
                  end else begin
                     state_q <= ST_PRIO;
                  end
               end
            end
            ST_PRIO: begin
               if (cnt_done) begin
                  state_q <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (sif.permit_on) begin
                  state_q <= ST_ACTIVE;
               end else if (!ACT_PEND) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_ACTIVE: begin
               if (ACT_DONE) begin
                  state_q <= ST_IDLE;
               end else if (run_one_permit && !sif.permit_on) begin
                  state_q <= ST_WAIT;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Priority phase length counter; it only runs in the priority state, so a
   // phase that is cut short always restarts from zero
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         cnt_q <= '0;
      end else if (state_q == ST_PRIO) begin
         cnt_q <= cnt_done ? '0 : cnt_q + 1'b1;
      end else begin
         cnt_q <= '0;
      end
   end

   // ------------------------------------------------------------------
   // Link pins
   // ------------------------------------------------------------------
   // Request stays low in permit-only mode since that arrangement has no line
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         REQ_OUT <= ~REQ_ACTIVE;
      end else if (state_q == ST_IDLE && ACT_PEND && !sel_one_permit) begin
         REQ_OUT <= REQ_ACTIVE;
      end else if (state_q == ST_ACTIVE && ACT_DONE) begin
         REQ_OUT <= ~REQ_ACTIVE;
      end else if (state_q == ST_WAIT && !sif.permit_on && !ACT_PEND) begin
         REQ_OUT <= ~REQ_ACTIVE;
      end
   end

   // Priority phase shows level, later phases show activity kind; the kind is
   // held through waiting and activity so the far side can tell tx from rx
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         PRIO_OUT <= ~PRIO_ACTIVE;
      end else if (state_q == ST_IDLE) begin
         PRIO_OUT <= (ACT_PEND && !sel_one_req && !sel_one_permit) ? ACT_HIGH_PRIO
                     : ~PRIO_ACTIVE;
      end else if (state_q == ST_PRIO) begin
         PRIO_OUT <= cnt_done ? kind_q : prio_q;
      end else if (!run_three) begin
         PRIO_OUT <= ~PRIO_ACTIVE;
      end
   end

   // ------------------------------------------------------------------
   // Radio side
   // ------------------------------------------------------------------
   // GO mirrors the active state and falls at the same edge that ends it,
   // so the radio never runs a cycle past the active state; permit loss ends that state only in permit-only mode
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         RADIO_GO <= 1'b0;
      end else begin
         RADIO_GO <= (state_q == ST_WAIT && sif.permit_on)
                     || (state_q == ST_IDLE && ACT_PEND && sel_one_req)
                     || (state_q == ST_ACTIVE && !ACT_DONE
                         && !(run_one_permit && !sif.permit_on));
      end
   end

   // Abort pulses once when permit is withdrawn in permit-only mode; the sequencer leaves active
   // at the same edge, so the pulse cannot repeat while the permit stays away
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         RADIO_ABORT <= 1'b0;
      end else begin
         RADIO_ABORT <= (state_q == ST_ACTIVE && !ACT_DONE
                         && run_one_permit && !sif.permit_on);
      end
   end

   // Refusal is a level while a request waits without permit, not a latch,
   // so it clears by itself once the permit arrives
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         REFUSED <= 1'b0;
      end else begin
         REFUSED <= (state_q == ST_WAIT && !sif.permit_on);
      end
   end

endmodule

/* File: shared/coex_pkg.sv */
// Purpose : Constants and types shared by the antenna-sharing handshake block
// Assumes : Single 50 MHz system clock, no software-visible registers
// Notes   : Mode codes are carried on the MODE_SEL port of the top module
package coex_pkg;

   // -----------------------------------------------------------------
   // Arrangement selection
   // -----------------------------------------------------------------
   localparam logic [1:0] MODE_THREE_WIRE  = 2'h0;
   localparam logic [1:0] MODE_ONE_REQUEST = 2'h1;
   localparam logic [1:0] MODE_ONE_PERMIT  = 2'h2;

   // -----------------------------------------------------------------
   // Line polarities
   // -----------------------------------------------------------------
   localparam logic REQ_ACTIVE    = 1'b1;
   localparam logic PRIO_ACTIVE   = 1'b1;
   localparam logic PERMIT_ACTIVE = 1'b0;

   // -----------------------------------------------------------------
   // Timing: priority phase before the activity-type phase
   // -----------------------------------------------------------------
   localparam int CLK_MHZ       = 50;
   localparam int PRIO_PHASE_NS = 1000;
   localparam int PRIO_PHASE_CYC = (PRIO_PHASE_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W         = 8;

   // Radio activity kind
   localparam logic KIND_RX = 1'b0;
   localparam logic KIND_TX = 1'b1;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_PRIO,
      ST_WAIT,
      ST_ACTIVE
   } hs_state_t;

endpackage

/* File: shared/coex_sync_if.sv */
// Purpose : Carries the permit line and its conditioned form between modules
// Assumes : Permit input already synchronous to the system clock
// Notes   : Filter drives the modport outputs, top module reads them
interface coex_sync_if;
   logic permit_raw;
   logic permit_on;

   modport filt (input permit_raw, output permit_on);
   modport user (output permit_raw, input permit_on);
endinterface

/* File: design/coex_permit_filter.sv */
// Purpose : Registers the active-low permit line as an active-high permission level
// Assumes : Input sampled on the system clock
// Notes   : Output lags the pin by one cycle; the sequencer timing counts on it
module coex_permit_filter
   import coex_pkg::*;
(
   input  wire logic  clk,
   input  wire logic  rst,
   coex_sync_if.filt  sif
);

   logic permit_q;

   // ------------------------------------------------------------------
   // Polarity decode and register
   // ------------------------------------------------------------------
   // Active-low line turned into an active-high permission level
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         permit_q <= 1'b0;
      end else begin
         permit_q <= (sif.permit_raw == PERMIT_ACTIVE);
      end
   end

   assign sif.permit_on = permit_q;

endmodule

/* File: tb/coex_sva.sv */
// Purpose: Port checks for the antenna-sharing handshake
// Assumes: MODE_SEL changes only while the block is idle
// Notes  : Bound to the top module from the bench
module coex_sva
   import coex_pkg::*;
#(
   parameter int PRIO_CYC = 2
)
(
   input wire logic       CLK_SYS,
   input wire logic       RST,
   input wire logic [1:0] MODE_SEL,
   input wire logic       ACT_PEND,
   input wire logic       ACT_HIGH_PRIO,
   input wire logic       ACT_KIND,
   input wire logic       ACT_DONE,
   input wire logic       PERMIT_N,
   input wire logic       REQ_OUT,
   input wire logic       PRIO_OUT,
   input wire logic       RADIO_GO,
   input wire logic       RADIO_ABORT
);
   timeunit 1ns;
   timeprecision 1ps;
   // Kind is checked one cycle late so either phase count reading passes
   localparam int KIND_AT = PRIO_CYC + 1;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   // ----------------------------------------------------------------
   // Handshake order
   // ----------------------------------------------------------------
   go_after_permit_a: assert property ($rose(RADIO_GO) && MODE_SEL != MODE_ONE_REQUEST
      |-> $past(PERMIT_N, 2) == PERMIT_ACTIVE) else $error("go without permit");
   req_before_go_a: assert property ($rose(RADIO_GO) && MODE_SEL == MODE_THREE_WIRE
      |-> REQ_OUT) else $error("go without request");
   grant_only_quiet_a: assert property (MODE_SEL == MODE_ONE_PERMIT
      |-> !REQ_OUT && !PRIO_OUT) else $error("request lines used in permit-only");
   req_only_go_a: assert property (MODE_SEL == MODE_ONE_REQUEST && ACT_PEND && !REQ_OUT
      |=> REQ_OUT && RADIO_GO) else $error("request-only did not go at once");
   prio_then_kind_a: assert property ($rose(REQ_OUT) && MODE_SEL == MODE_THREE_WIRE
      |-> PRIO_OUT == $past(ACT_HIGH_PRIO) ##KIND_AT (!REQ_OUT || PRIO_OUT == ACT_KIND))
      else $error("priority line sharing wrong");
   // ----------------------------------------------------------------
   // Stopping activity
   // ----------------------------------------------------------------
   abort_on_loss_a: assert property (MODE_SEL == MODE_ONE_PERMIT && RADIO_GO
      && PERMIT_N != PERMIT_ACTIVE && $past(PERMIT_N) == PERMIT_ACTIVE
      |-> ##2 (RADIO_ABORT && !RADIO_GO)) else $error("no stop");
   abort_pulse_a: assert property (RADIO_ABORT |=> !RADIO_ABORT)
      else $error("abort longer than one cycle");
   done_release_a: assert property (RADIO_GO && ACT_DONE |=> !RADIO_GO && !REQ_OUT)
      else $error("request held after done");
endmodule

/* File: tb/wlan_model.sv */
// Purpose: Behavioural far-side radio driving the permit line
// Assumes: Same clock as the device end
// Notes  : lat sets how slowly a grant follows; allow low refuses
module wlan_model
   import coex_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       req,
   input  wire logic       allow,
   input  wire logic       free,
   input  wire logic [3:0] lat,
   output logic            permit_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       want;
   logic [3:0] wait_q;
   assign want = allow && (req || free);
   // Grant after lat cycles, otherwise hold inactive and steady
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wait_q   <= 4'h0;
         permit_n <= ~PERMIT_ACTIVE;
      end else begin
         wait_q   <= want ? wait_q + {3'h0, wait_q != 4'hf} : 4'h0;
         permit_n <= (want && wait_q >= lat) ? PERMIT_ACTIVE : ~PERMIT_ACTIVE;
      end
   end
endmodule

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the antenna-sharing handshake
// Assumes: Inputs change 1 ns after the rising edge
// Notes  : Short priority phase keeps the run brief
module tb
   import coex_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PRIO_CYC = 2;
   logic       clk = 1'b0, rst = 1'b1, pend = 1'b0, hprio = 1'b0, kind = 1'b0, done = 1'b0;
   logic       allow = 1'b0, free = 1'b0, permit_n, req, prio, go, abort, refused;
   logic [1:0] mode = MODE_THREE_WIRE;
   logic [3:0] lat = 4'h0;
   int         err_total = 0, checks_done = 0;
   // 50 MHz system clock
   always #10 clk = ~clk;
   coex_handshake #(.PRIO_CYC(PRIO_CYC)) coex_handshake_inst (.CLK_SYS(clk), .RST(rst),
      .MODE_SEL(mode), .ACT_PEND(pend), .ACT_HIGH_PRIO(hprio), .ACT_KIND(kind),
      .ACT_DONE(done), .PERMIT_N(permit_n), .REQ_OUT(req), .PRIO_OUT(prio),
      .RADIO_GO(go), .RADIO_ABORT(abort), .REFUSED(refused));
   wlan_model wlan_model_inst (.clk(clk), .rst(rst), .req(req), .allow(allow), .free(free),
      .lat(lat), .permit_n(permit_n));
   // ----------------------------------------------------------------
   // Shared helpers
   // ----------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string name, input logic exp, input logic got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %b seen %b", name, exp, got);
      end
   endtask
   task automatic wait_go();
      int n;
      n = 0;
      while (go !== 1'b1 && n < 40) begin
         tick(1);
         n++;
      end
      chk("radio_go", 1'b1, go);
   endtask
   // Ends an activity and leaves idle time so the permit filter settles
   task automatic end_act();
      done = 1'b1;
      pend = 1'b0;
      tick(1);
      done = 1'b0;
      chk("radio_go", 1'b0, go);
      chk("request", 1'b0, req);
      tick(4);
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic three_wire(input logic p, input logic k);
      mode = MODE_THREE_WIRE;
      hprio = p;
      kind = k;
      lat = 4'h6;
      allow = 1'b1;
      pend = 1'b1;
      tick(1);
      chk("request", REQ_ACTIVE, req);
      chk("priority", p, prio);
      tick(PRIO_CYC + 1);
      chk("kind", k, prio);
      chk("radio_go", 1'b0, go);
      wait_go();
      chk("request", 1'b1, req);
      end_act();
   endtask
   task automatic req_only();
      mode = MODE_ONE_REQUEST;
      allow = 1'b0;
      pend = 1'b1;
      tick(1);
      chk("request", 1'b1, req);
      chk("radio_go", 1'b1, go);
      tick(3);
      chk("radio_go", 1'b1, go);
      end_act();
   endtask
   task automatic permit_only();
      mode = MODE_ONE_PERMIT;
      free = 1'b1;
      lat = 4'h0;
      pend = 1'b1;
      tick(4);
      chk("refused", 1'b1, refused);
      chk("radio_go", 1'b0, go);
      chk("request", 1'b0, req);
      allow = 1'b1;
      wait_go();
      allow = 1'b0;
      // Model edge, pin filter and sequencer each add one cycle before the stop
      tick(3);
      chk("abort", 1'b1, abort);
      chk("radio_go", 1'b0, go);
      tick(1);
      chk("abort", 1'b0, abort);
      chk("refused", 1'b1, refused);
      pend = 1'b0;
      tick(3);
   endtask
   // Main sequence, reset held for two cycles
   initial begin
      tick(2);
      rst = 1'b0;
      tick(2);
      for (int i = 0; i < 4; i++) begin
         three_wire(i[1], i[0]);
      end
      req_only();
      permit_only();
      print_verdict();
   end
   // Watchdog, well beyond the fewer than a hundred cycles the scenarios need
   initial begin
      #20us;
      err_total++;
      print_verdict();
   end
endmodule
bind coex_handshake coex_sva #(.PRIO_CYC(PRIO_CYC)) coex_sva_inst (.CLK_SYS(CLK_SYS),
   .RST(RST), .MODE_SEL(MODE_SEL), .ACT_PEND(ACT_PEND), .ACT_HIGH_PRIO(ACT_HIGH_PRIO),
   .ACT_KIND(ACT_KIND), .ACT_DONE(ACT_DONE), .PERMIT_N(PERMIT_N), .REQ_OUT(REQ_OUT),
   .PRIO_OUT(PRIO_OUT), .RADIO_GO(RADIO_GO), .RADIO_ABORT(RADIO_ABORT));
